/* nir_defines.svh */
// offsets, field positions, reset values and codes of the node-id and interrupt redirect block
`ifndef NIR_DEFINES_SVH
`define NIR_DEFINES_SVH

// configuration offsets (byte addresses inside a function)
`define NIR_OFF_VENDOR_IDENT 12'h000
`define NIR_OFF_DEVICE_IDENT 12'h002
`define NIR_OFF_NODE_ID_CONFIG 12'h0C0
`define NIR_OFF_INTERRUPT_CONFIG 12'h0C8
`define NIR_FUNC_MAIN 3'h0

// node_id_config fields (lsb of each 3-bit field)
`define NIR_NODE_CTRL_LSB 13
`define NIR_LEGACY_LSB 10
`define NIR_LOCK_LSB 5
`define NIR_LOCAL_LSB 0
`define NIR_NODE_ID_RESET 32'h0000_0000
`define NIR_NODE_ID_WMASK 32'h0000_FCE7

// interrupt_config fields
`define NIR_OVR_BIT 18
`define NIR_MODE_BIT 17
`define NIR_CHK_BIT 16
`define NIR_HASH_LSB 8
`define NIR_REDIR_LSB 4
`define NIR_FORCE_BIT 1
`define NIR_XAPIC_BIT 0
`define NIR_INT_CFG_RESET 32'h0000_0001
`define NIR_INT_CFG_WMASK 32'h0007_0773

// redirection schemes
`define NIR_SCHEME_FIXED 3'h0
`define NIR_SCHEME_LAST 3'h1
`define NIR_SCHEME_HASH 3'h2

// hash bit selections
`define NIR_HASH_SEL_74 3'h0
`define NIR_HASH_SEL_63 3'h1
`define NIR_HASH_SEL_41 3'h2
`define NIR_HASH_SEL_30 3'h3

`endif

/* nir_pkg.sv */
// types shared by the node-id and interrupt redirect block
package nir_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] func;
		logic [11:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} nir_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
	} nir_cfg_rsp_t;

	typedef struct packed {
		logic valid;
		logic [31:0] logical_apic_identifier;
		logic flat_cluster_mode;
		logic extended_apic_enable;
	} nir_prio_msg_t;

	typedef struct packed {
		logic [2:0] node_controller_node;
		logic [2:0] legacy_socket_node;
		logic [2:0] lock_master_node;
		logic [2:0] local_socket_node;
	} nir_node_ids_t;

endpackage : nir_pkg

/* nir_last_mem.sv */
// per-vector memory of the last chosen redirection target
`timescale 1ns/1ns
module nir_last_mem #(
	parameter int DEPTH = 256,
	parameter int AW = 8,
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port, data one cycle later
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic rd_filled,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];
	// the array itself has no reset, so a separate filled vector marks entries ever written
	logic [DEPTH-1:0] filled;
	logic [DEPTH-1:0] next_filled;
	logic next_rd_filled;
	logic [WIDTH-1:0] next_rd_data;

	always_comb begin
		next_filled = filled;
		next_rd_filled = rd_filled;
		next_rd_data = rd_data;
		if (wr_en) begin
			next_filled[wr_addr] = 1'b1;
		end
		if (rd_en) begin
			next_rd_filled = filled[rd_addr];
			next_rd_data = mem[rd_addr];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			filled <= '0;
			rd_filled <= 1'b0;
			rd_data <= '0;
		end else begin
			filled <= next_filled;
			rd_filled <= next_rd_filled;
			rd_data <= next_rd_data;
		end
	end

endmodule : nir_last_mem

/* nir_redirect_pick.sv */
// choice of a lowest-priority target among the enabled APICs
`timescale 1ns/1ns
`include "nir_defines.svh"
module nir_redirect_pick #(
	parameter int NUM_APICS = 16,
	parameter int IW = 4
) (
	// configuration
	input wire logic [2:0] scheme,
	input wire logic [2:0] hash_sel,
	input wire logic cluster_mode,
	input wire logic extended_mode,
	// request
	input wire logic [7:0] vector,
	input wire logic [NUM_APICS-1:0] enabled,
	input wire logic last_filled,
	input wire logic [IW-1:0] last_target,
	// choice
	output logic found,
	output logic [IW-1:0] target
);

	// first enabled APIC at or after start, wrapping round
	function automatic logic [IW:0] nir_first_from(input logic [NUM_APICS-1:0] en, input logic [IW-1:0] start);
		logic [IW:0] res;
		int idx;
		res = '0;
		for (int i = NUM_APICS - 1; i >= 0; i--) begin
			idx = (int'(start) + i) % NUM_APICS;
			if (en[idx]) begin
				res = {1'b1, IW'(idx)};
			end
		end
		return res;
	endfunction : nir_first_from

	// vector nibble chosen by the hash selection; reserved codes fall back to bits 7:4
	function automatic logic [3:0] nir_hash_nibble(input logic [2:0] sel, input logic [7:0] vec);
		case (sel)
			`NIR_HASH_SEL_63: return vec[6:3];
			`NIR_HASH_SEL_41: return vec[4:1];
			`NIR_HASH_SEL_30: return vec[3:0];
			default: return vec[7:4];
		endcase
	endfunction : nir_hash_nibble

	logic [3:0] nibble;
	logic [IW-1:0] hash_start;
	logic [IW:0] fixed_pick;
	logic [IW:0] hash_pick;

	always_comb begin
		nibble = nir_hash_nibble(hash_sel, vector); // see R07
		// cluster uses four hash bits, flat the low two of them
		hash_start = cluster_mode ? IW'(nibble) : IW'(nibble[1:0]); // see R07
		fixed_pick = nir_first_from(enabled, '0); // see R08
		hash_pick = nir_first_from(enabled, hash_start); // see R10
		found = fixed_pick[IW];
		target = fixed_pick[IW-1:0];
		case (scheme)
			`NIR_SCHEME_LAST: begin
				// a stale or disabled remembered target falls back to fixed priority
				if (extended_mode && last_filled && enabled[last_target]) begin // see R09
					found = 1'b1;
					target = last_target;
				end
			end
			`NIR_SCHEME_HASH: begin
				found = hash_pick[IW]; // see R10
				target = hash_pick[IW-1:0];
			end
			default: begin
				found = fixed_pick[IW]; // see R08
				target = fixed_pick[IW-1:0];
			end
		endcase
	end

endmodule : nir_redirect_pick

/* nir_config.sv */
// node-id and interrupt redirect configuration block with its redirection pipeline
//
// Functional notes
// R01 - four 3-bit node identifiers in node register
// R02 - mode bit read-only while override clear
// R03 - override set: software writes mode, messages ignored
// R04 - software should clear override after one change
// R05 - mode bit shows filter, firmware and messages update
// R06 - check enable needs non-zero logical id
// R07 - hash selection picks vector bits cluster/flat
// R08 - fixed priority: first enabled, also undefined codes
// R09 - code 001 reuses last target, extended mode
// R10 - code 010 round robin from vector hash
// R11 - writing 1 forces second-gen mode, 0 ignored
// R12 - extended enable resets 1, written and messaged
// R13 - fixed vendor and device codes per function
// R14 - reserved bits read zero, ignore writes
`timescale 1ns/1ns
`include "nir_defines.svh"
module nir_config
	import nir_pkg::*;
#(
	// identification codes; values are arbitrary
	parameter logic [15:0] VENDOR_CODE = 16'h1AB0,
	parameter logic [15:0] DEVICE_CODE_MAIN = 16'h0C10,
	parameter logic [15:0] DEVICE_CODE_OTHER = 16'h0C12,
	parameter int NUM_APICS = 16,
	parameter int VECTORS = 256
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration access
	input wire nir_pkg::nir_cfg_req_t cfg_req,
	output nir_pkg::nir_cfg_rsp_t cfg_rsp,
	// task priority update messages
	input wire nir_pkg::nir_prio_msg_t priority_update_message,
	// configuration state seen by the interrupt logic
	output nir_pkg::nir_node_ids_t node_ids,
	output logic flat_cluster_mode,
	output logic extended_apic_enable,
	output logic force_second_gen_apic,
	// lowest-priority redirection request
	input wire logic redir_req_valid,
	input wire logic [7:0] redir_vector,
	input wire logic [NUM_APICS-1:0] redir_enabled,
	// redirection answer
	output logic redir_rsp_valid,
	output logic redir_rsp_found,
	output logic [$clog2(NUM_APICS)-1:0] redir_rsp_target
);
	import nir_pkg::*;

	localparam int IW = $clog2(NUM_APICS);

	////////////////////////////////////////////////////////////////////////////////
	// register access

	function automatic logic [31:0] nir_byte_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : nir_byte_mask

	// register state
	logic [31:0] node_id_config;
	logic [31:0] next_node_id_config;
	logic [31:0] interrupt_config;
	logic [31:0] next_interrupt_config;
	logic force_latched;
	logic next_force_latched;
	nir_cfg_rsp_t next_cfg_rsp;

	// decode of the current access
	logic [31:0] wmask;
	logic [31:0] node_merge;
	logic [31:0] int_merge;
	logic hit_main;
	logic wr_node;
	logic wr_int;
	logic msg_sample_ok;

	always_comb begin
		wmask = nir_byte_mask(cfg_req.byte_en);
		hit_main = cfg_req.valid && (cfg_req.func == `NIR_FUNC_MAIN);
		wr_node = hit_main && cfg_req.write && (cfg_req.offset[11:2] == `NIR_OFF_NODE_ID_CONFIG >> 2);
		wr_int = hit_main && cfg_req.write && (cfg_req.offset[11:2] == `NIR_OFF_INTERRUPT_CONFIG >> 2);
		// only the defined fields take write data; reserved bits stay zero
		node_merge = (node_id_config & ~(wmask & `NIR_NODE_ID_WMASK)) |
			(cfg_req.wdata & wmask & `NIR_NODE_ID_WMASK); // see R14
		int_merge = (interrupt_config & ~(wmask & `NIR_INT_CFG_WMASK)) |
			(cfg_req.wdata & wmask & `NIR_INT_CFG_WMASK); // see R14

		// a message may move the mode only when the identifier check passes or is off
		msg_sample_ok = priority_update_message.valid && !interrupt_config[`NIR_OVR_BIT] &&
			(!interrupt_config[`NIR_CHK_BIT] ||
			(priority_update_message.logical_apic_identifier != 32'h0000_0000)); // see R06
	end

	// next register values
	always_comb begin
		next_node_id_config = node_id_config;
		next_interrupt_config = interrupt_config;
		next_force_latched = force_latched;
		if (wr_node) begin
			next_node_id_config = node_merge; // see R01
		end

		// message updates first, so a software write in the same cycle wins
		if (msg_sample_ok) begin
			next_interrupt_config[`NIR_MODE_BIT] = priority_update_message.flat_cluster_mode; // see R05
		end
		if (priority_update_message.valid) begin
			next_interrupt_config[`NIR_XAPIC_BIT] = priority_update_message.extended_apic_enable; // see R12
		end
		if (wr_int) begin
			next_interrupt_config[`NIR_OVR_BIT] = int_merge[`NIR_OVR_BIT];
			next_interrupt_config[`NIR_CHK_BIT] = int_merge[`NIR_CHK_BIT];
			next_interrupt_config[`NIR_HASH_LSB +: 3] = int_merge[`NIR_HASH_LSB +: 3]; // see R07
			next_interrupt_config[`NIR_REDIR_LSB +: 3] = int_merge[`NIR_REDIR_LSB +: 3]; // see R08
			next_interrupt_config[`NIR_XAPIC_BIT] = int_merge[`NIR_XAPIC_BIT]; // see R12
			// the override in force before this write decides whether the mode bit moves
			if (interrupt_config[`NIR_OVR_BIT]) begin // see R02
				next_interrupt_config[`NIR_MODE_BIT] = int_merge[`NIR_MODE_BIT]; // see R03
			end
			// the force bit only ever sets; a written zero changes nothing
			if (int_merge[`NIR_FORCE_BIT] && wmask[`NIR_FORCE_BIT]) begin // see R11
				next_force_latched = 1'b1;
			end
		end

		next_interrupt_config[`NIR_FORCE_BIT] = next_force_latched;
	end

	// read answer, one cycle after the access
	always_comb begin
		next_cfg_rsp.valid = cfg_req.valid && !cfg_req.write;
		next_cfg_rsp.rdata = 32'h0000_0000;
		if (cfg_req.valid && !cfg_req.write) begin
			case (cfg_req.offset[11:2])
				`NIR_OFF_VENDOR_IDENT >> 2: begin
					// the device code shares the first word, upper half
					next_cfg_rsp.rdata = {(hit_main ? DEVICE_CODE_MAIN : DEVICE_CODE_OTHER), VENDOR_CODE}; // see R13
				end
				`NIR_OFF_NODE_ID_CONFIG >> 2: begin
					next_cfg_rsp.rdata = hit_main ? node_id_config : 32'h0000_0000;
				end
				`NIR_OFF_INTERRUPT_CONFIG >> 2: begin
					next_cfg_rsp.rdata = hit_main ? interrupt_config : 32'h0000_0000;
				end
				default: begin
					next_cfg_rsp.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// outputs leave flops, in step with the registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			node_id_config <= `NIR_NODE_ID_RESET;
			interrupt_config <= `NIR_INT_CFG_RESET; // see R12
			force_latched <= 1'b0;

			cfg_rsp <= '0;
			node_ids <= '0;
			flat_cluster_mode <= 1'b0;
			extended_apic_enable <= 1'b1;
			force_second_gen_apic <= 1'b0;
		end else begin
			node_id_config <= next_node_id_config;
			interrupt_config <= next_interrupt_config;
			force_latched <= next_force_latched;

			cfg_rsp <= next_cfg_rsp;
			node_ids.node_controller_node <= next_node_id_config[`NIR_NODE_CTRL_LSB +: 3]; // see R01
			node_ids.legacy_socket_node <= next_node_id_config[`NIR_LEGACY_LSB +: 3];
			node_ids.lock_master_node <= next_node_id_config[`NIR_LOCK_LSB +: 3];
			node_ids.local_socket_node <= next_node_id_config[`NIR_LOCAL_LSB +: 3];
			flat_cluster_mode <= next_interrupt_config[`NIR_MODE_BIT]; // see R05
			extended_apic_enable <= next_interrupt_config[`NIR_XAPIC_BIT];
			force_second_gen_apic <= next_force_latched;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// redirection pipeline: request, memory read, choice

	// stage one: request as taken
	logic s1_valid;
	logic [7:0] s1_vector;
	logic [NUM_APICS-1:0] s1_enabled;
	logic next_s1_valid;
	logic [7:0] next_s1_vector;
	logic [NUM_APICS-1:0] next_s1_enabled;

	// choice made last cycle
	logic fwd_valid;
	logic [7:0] fwd_vector;
	logic [IW-1:0] fwd_target;
	logic next_fwd_valid;
	logic [7:0] next_fwd_vector;
	logic [IW-1:0] next_fwd_target;

	// memory answer and choice
	logic mem_filled;
	logic [IW-1:0] mem_target;
	logic last_filled;
	logic [IW-1:0] last_target;
	logic pick_found;
	logic [IW-1:0] pick_target;
	logic next_rsp_valid;
	logic next_rsp_found;
	logic [IW-1:0] next_rsp_target;

	always_comb begin
		next_s1_valid = redir_req_valid;
		next_s1_vector = redir_req_valid ? redir_vector : s1_vector;
		next_s1_enabled = redir_req_valid ? redir_enabled : s1_enabled;
		// the memory read happened before the previous choice was written, so bypass it
		last_filled = mem_filled;
		last_target = mem_target;
		if (fwd_valid && fwd_vector == s1_vector) begin
			last_filled = 1'b1;
			last_target = fwd_target;
		end

		next_fwd_valid = s1_valid && pick_found;
		next_fwd_vector = s1_vector;
		next_fwd_target = pick_target;

		next_rsp_valid = s1_valid;
		next_rsp_found = s1_valid && pick_found;
		next_rsp_target = s1_valid ? pick_target : redir_rsp_target;
	end

	// one entry per vector
	nir_last_mem #(
		.DEPTH(VECTORS),
		.AW(8),
		.WIDTH(IW)
	) u_last_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(s1_valid && pick_found),
		.wr_addr(s1_vector),
		.wr_data(pick_target),
		.rd_en(redir_req_valid),
		.rd_addr(redir_vector),
		.rd_filled(mem_filled),
		.rd_data(mem_target)
	);

	// choice is combinational on stage one
	nir_redirect_pick #(
		.NUM_APICS(NUM_APICS),
		.IW(IW)
	) u_pick (
		.scheme(interrupt_config[`NIR_REDIR_LSB +: 3]), // see R08
		.hash_sel(interrupt_config[`NIR_HASH_LSB +: 3]), // see R07
		.cluster_mode(interrupt_config[`NIR_MODE_BIT]),
		.extended_mode(interrupt_config[`NIR_XAPIC_BIT] || force_latched), // see R09
		.vector(s1_vector),
		.enabled(s1_enabled),
		.last_filled(last_filled),
		.last_target(last_target),
		.found(pick_found),
		.target(pick_target)
	);

	// pipeline registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_valid <= 1'b0;
			s1_vector <= 8'h00;
			s1_enabled <= '0;

			fwd_valid <= 1'b0;
			fwd_vector <= 8'h00;
			fwd_target <= '0;

			redir_rsp_valid <= 1'b0;
			redir_rsp_found <= 1'b0;
			redir_rsp_target <= '0;
		end else begin
			s1_valid <= next_s1_valid;
			s1_vector <= next_s1_vector;
			s1_enabled <= next_s1_enabled;

			fwd_valid <= next_fwd_valid;
			fwd_vector <= next_fwd_vector;
			fwd_target <= next_fwd_target;

			redir_rsp_valid <= next_rsp_valid;
			redir_rsp_found <= next_rsp_found;
			redir_rsp_target <= next_rsp_target;
		end
	end

endmodule : nir_config

/* nir_config_properties.sv */
// port assertions of the node-id and interrupt redirect block
`timescale 1ns/1ns
`include "nir_defines.svh"
module nir_config_checker
	import nir_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = 16'h1AB0,
	parameter logic [15:0] DEVICE_CODE_MAIN = 16'h0C10,
	parameter int NUM_APICS = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// access and messages
	input wire nir_pkg::nir_cfg_req_t cfg_req,
	input wire nir_pkg::nir_cfg_rsp_t cfg_rsp,
	input wire nir_pkg::nir_prio_msg_t priority_update_message,
	// state
	input wire nir_pkg::nir_node_ids_t node_ids,
	input wire logic flat_cluster_mode,
	input wire logic extended_apic_enable,
	input wire logic force_second_gen_apic,
	// redirection
	input wire logic redir_req_valid,
	input wire logic [NUM_APICS-1:0] redir_enabled,
	input wire logic redir_rsp_valid,
	input wire logic redir_rsp_found
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic rd0;
	logic wr_int;
	logic wr_node;
	logic msg;
	logic ovr;
	logic chk;
	logic next_ovr;
	logic next_chk;
	assign rd0 = cfg_req.valid && !cfg_req.write && cfg_req.func == `NIR_FUNC_MAIN;
	assign wr_int = cfg_req.valid && cfg_req.write && cfg_req.func == `NIR_FUNC_MAIN
		&& {cfg_req.offset[11:2], 2'b00} == `NIR_OFF_INTERRUPT_CONFIG;
	assign wr_node = cfg_req.valid && cfg_req.write && cfg_req.func == `NIR_FUNC_MAIN
		&& {cfg_req.offset[11:2], 2'b00} == `NIR_OFF_NODE_ID_CONFIG && cfg_req.byte_en == 4'hF;
	// a same-cycle register write wins, so message checks skip those cycles
	assign msg = priority_update_message.valid && !wr_int;
	////////////////////////////////////////
	// shadow of override and check enable, both in byte lane 2
	always_comb begin
		next_ovr = ovr;
		next_chk = chk;
		if (wr_int && cfg_req.byte_en[2]) begin
			next_ovr = cfg_req.wdata[18];
			next_chk = cfg_req.wdata[16];
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ovr <= 1'b0;
			chk <= 1'b0;
		end else begin
			ovr <= next_ovr;
			chk <= next_chk;
		end
	end
	////////////////////////////////////////
	property p_node_fields;
		wr_node |=> node_ids == $past({cfg_req.wdata[15:10], cfg_req.wdata[7:5], cfg_req.wdata[2:0]});
	endproperty
	a_node_fields: assert property (p_node_fields) else $error("node ids differ from write");
	property p_mode_locked;
		$changed(flat_cluster_mode) |-> $past(priority_update_message.valid) || $past(wr_int && ovr);
	endproperty
	a_mode_locked: assert property (p_mode_locked) else $error("mode bit changed without cause");
	property p_ovr_ignores_msg;
		msg && ovr |=> $stable(flat_cluster_mode);
	endproperty
	a_ovr_ignores_msg: assert property (p_ovr_ignores_msg) else $error("message changed locked mode");
	property p_msg_mode;
		msg && !ovr && (!chk || priority_update_message.logical_apic_identifier != 0)
			|=> flat_cluster_mode == $past(priority_update_message.flat_cluster_mode);
	endproperty
	a_msg_mode: assert property (p_msg_mode) else $error("message mode not taken");
	property p_zero_id;
		msg && chk && priority_update_message.logical_apic_identifier == 0 |=> $stable(flat_cluster_mode);
	endproperty
	a_zero_id: assert property (p_zero_id) else $error("zero id message changed mode");
	property p_force_sticky;
		force_second_gen_apic || (wr_int && cfg_req.byte_en[0] && cfg_req.wdata[1]) |=> force_second_gen_apic;
	endproperty
	a_force_sticky: assert property (p_force_sticky) else $error("force bit not set or lost");
	property p_msg_xapic;
		msg |=> extended_apic_enable == $past(priority_update_message.extended_apic_enable);
	endproperty
	a_msg_xapic: assert property (p_msg_xapic) else $error("extended enable not taken");
	property p_ident;
		rd0 && cfg_req.offset[11:2] == 10'h000 |=> cfg_rsp.valid && cfg_rsp.rdata == {DEVICE_CODE_MAIN, VENDOR_CODE};
	endproperty
	a_ident: assert property (p_ident) else $error("identification codes wrong");
	property p_node_rsvd;
		rd0 && {cfg_req.offset[11:2], 2'b00} == `NIR_OFF_NODE_ID_CONFIG
			|=> (cfg_rsp.rdata & ~`NIR_NODE_ID_WMASK) == 32'h0000_0000;
	endproperty
	a_node_rsvd: assert property (p_node_rsvd) else $error("reserved node bits set");
	property p_redir_found;
		redir_req_valid |-> ##2 redir_rsp_valid && redir_rsp_found == (|$past(redir_enabled, 2));
	endproperty
	a_redir_found: assert property (p_redir_found) else $error("redirection answer wrong");
endmodule : nir_config_checker

bind nir_config nir_config_checker #(.VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE_MAIN(DEVICE_CODE_MAIN),
	.NUM_APICS(NUM_APICS)) u_nir_config_checker (.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req),
	.cfg_rsp(cfg_rsp), .priority_update_message(priority_update_message), .node_ids(node_ids),
	.flat_cluster_mode(flat_cluster_mode), .extended_apic_enable(extended_apic_enable),
	.force_second_gen_apic(force_second_gen_apic), .redir_req_valid(redir_req_valid),
	.redir_enabled(redir_enabled), .redir_rsp_valid(redir_rsp_valid), .redir_rsp_found(redir_rsp_found));

/* nir_sw_model.sv */
// software access and priority message source for the configuration block
`timescale 1ns/1ns
module nir_sw_model
	import nir_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// configuration access
	output nir_pkg::nir_cfg_req_t cfg_req,
	input wire nir_pkg::nir_cfg_rsp_t cfg_rsp,
	// priority messages
	output nir_pkg::nir_prio_msg_t priority_update_message
);
	initial begin
		cfg_req = '0;
		priority_update_message = '0;
	end
	task automatic cfg_access(input logic wr, input logic [2:0] fn, input logic [11:0] off,
		input logic [31:0] wd, output nir_cfg_rsp_t rsp);
		@(posedge clk_sys);
		#1;
		cfg_req = '{valid: 1'b1, write: wr, func: fn, offset: off, byte_en: 4'hF, wdata: wd};
		@(posedge clk_sys);
		#1;
		// the read answer stands one cycle only, so it is taken before the lines change
		rsp = '0;
		if (!wr) begin
			rsp = cfg_rsp;
		end
		// released lines show the inverse so stale data is never mistaken for live
		cfg_req = '{valid: 1'b0, write: ~wr, func: ~fn, offset: ~off, byte_en: 4'h0, wdata: ~wd};
	endtask : cfg_access
	task automatic send_msg(input logic [31:0] id, input logic mode, input logic xapic);
		@(posedge clk_sys);
		#1;
		priority_update_message = '{1'b1, id, mode, xapic};
		@(posedge clk_sys);
		#1;
		priority_update_message = '{1'b0, ~id, ~mode, ~xapic};
	endtask : send_msg
	// one-time mode change; override goes back to 0 so messages steer the filter again
	task automatic mode_override_once(input logic mode);
		nir_cfg_rsp_t rsp;
		cfg_access(1'b1, 3'h0, 12'h0C8, 32'h0004_0001, rsp);
		cfg_access(1'b1, 3'h0, 12'h0C8, 32'h0004_0001 | {14'h0, mode, 17'h0}, rsp);
		cfg_access(1'b1, 3'h0, 12'h0C8, 32'h0000_0001 | {14'h0, mode, 17'h0}, rsp);
	endtask : mode_override_once
endmodule : nir_sw_model

/* tb.sv */
// self-checking testbench of the node-id and interrupt redirect block
`timescale 1ns/1ns
module tb;
	import nir_pkg::*;
	localparam logic [15:0] VEND = 16'h5A31; // arbitrary code
	localparam logic [15:0] DEV_MAIN = 16'h3C01; // arbitrary code
	localparam logic [15:0] DEV_OTHER = 16'h3C02; // arbitrary code
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	nir_cfg_req_t cfg_req;
	nir_cfg_rsp_t cfg_rsp;
	nir_prio_msg_t priority_update_message;
	nir_node_ids_t node_ids;
	logic flat_cluster_mode;
	logic extended_apic_enable;
	logic force_second_gen_apic;
	logic redir_req_valid = 1'b0;
	logic [7:0] redir_vector = 8'h00;
	logic [15:0] redir_enabled = 16'h0000;
	logic redir_rsp_valid;
	logic redir_rsp_found;
	logic [3:0] redir_rsp_target;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #10 clk_sys = ~clk_sys;
	nir_config #(.VENDOR_CODE(VEND), .DEVICE_CODE_MAIN(DEV_MAIN), .DEVICE_CODE_OTHER(DEV_OTHER)) u_nir_config (
		.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.priority_update_message(priority_update_message), .node_ids(node_ids),
		.flat_cluster_mode(flat_cluster_mode), .extended_apic_enable(extended_apic_enable),
		.force_second_gen_apic(force_second_gen_apic), .redir_req_valid(redir_req_valid),
		.redir_vector(redir_vector), .redir_enabled(redir_enabled), .redir_rsp_valid(redir_rsp_valid),
		.redir_rsp_found(redir_rsp_found), .redir_rsp_target(redir_rsp_target));
	nir_sw_model u_nir_sw_model (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.priority_update_message(priority_update_message));
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic rd(input logic [2:0] fn, input logic [11:0] off, input logic [31:0] exp);
		nir_cfg_rsp_t rsp;
		u_nir_sw_model.cfg_access(1'b0, fn, off, 32'h0000_0000, rsp);
		check("read valid", 32'h1, 32'(rsp.valid));
		check($sformatf("read %h", off), exp, rsp.rdata);
	endtask : rd
	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		nir_cfg_rsp_t rsp;
		u_nir_sw_model.cfg_access(1'b1, 3'h0, off, d, rsp);
	endtask : wr
	task automatic redir(input logic [7:0] vec, input logic [15:0] en, input logic fnd, input logic [3:0] tgt);
		@(posedge clk_sys);
		#1;
		redir_req_valid = 1'b1;
		redir_vector = vec;
		redir_enabled = en;
		@(posedge clk_sys);
		#1;
		redir_req_valid = 1'b0;
		redir_vector = ~vec;
		redir_enabled = ~en;
		@(posedge clk_sys);
		#1;
		check("redir valid", 32'h1, 32'(redir_rsp_valid));
		check("redir found", 32'(fnd), 32'(redir_rsp_found));
		if (fnd) check($sformatf("redir target %h", vec), 32'(tgt), 32'(redir_rsp_target));
	endtask : redir
	task automatic apply_reset();
		rst = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		rst = 1'b0;
	endtask : apply_reset
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	task automatic t_ident_and_nodes();
		rd(3'h0, 12'h000, {DEV_MAIN, VEND});
		rd(3'h1, 12'h000, {DEV_OTHER, VEND});
		rd(3'h0, 12'h0C8, 32'h0000_0001);
		wr(12'h000, 32'hFFFF_FFFF);
		rd(3'h0, 12'h000, {DEV_MAIN, VEND});
		rd(3'h0, 12'h0C4, 32'h0000_0000);
		rd(3'h0, 12'h0C0, 32'h0000_0000);
		wr(12'h0C0, 32'hFFFF_FFFF);
		rd(3'h0, 12'h0C0, 32'h0000_FCE7);
		check("node ids", 32'hFFF, 32'(node_ids));
		wr(12'h0C0, 32'h0000_A8A3);
		rd(3'h0, 12'h0C0, 32'h0000_A8A3);
		check("node ids", 32'hAAB, 32'(node_ids));
	endtask : t_ident_and_nodes
	task automatic t_mode_control();
		wr(12'h0C8, 32'h0007_0771);
		rd(3'h0, 12'h0C8, 32'h0005_0771);
		u_nir_sw_model.send_msg(32'h1, 1'b1, 1'b1);
		check("mode", 32'h0, 32'(flat_cluster_mode));
		wr(12'h0C8, 32'h0006_0771);
		check("mode", 32'h1, 32'(flat_cluster_mode));
		u_nir_sw_model.mode_override_once(1'b0);
		rd(3'h0, 12'h0C8, 32'h0000_0001);
		u_nir_sw_model.send_msg(32'h1, 1'b1, 1'b1);
		check("mode", 32'h1, 32'(flat_cluster_mode));
		wr(12'h0C8, 32'h0001_0001);
		rd(3'h0, 12'h0C8, 32'h0003_0001);
		u_nir_sw_model.send_msg(32'h0, 1'b0, 1'b1);
		check("mode", 32'h1, 32'(flat_cluster_mode));
		u_nir_sw_model.send_msg(32'h2, 1'b0, 1'b1);
		check("mode", 32'h0, 32'(flat_cluster_mode));
		wr(12'h0C8, 32'h0000_0001);
		u_nir_sw_model.send_msg(32'h0, 1'b1, 1'b0);
		rd(3'h0, 12'h0C8, 32'h0002_0000);
		wr(12'h0C8, 32'h0000_0002);
		wr(12'h0C8, 32'h0000_0000);
		rd(3'h0, 12'h0C8, 32'h0002_0002);
		check("force", 32'h1, 32'(force_second_gen_apic));
	endtask : t_mode_control
	task automatic t_redirect();
		logic [3:0] flat_exp [4] = '{4'h2, 4'h0, 4'h2, 4'h1};
		logic [3:0] clus_exp [4] = '{4'hA, 4'h4, 4'h2, 4'h5};
		redir(8'h35, 16'h0006, 1'b1, 4'h1);
		redir(8'h35, 16'h0000, 1'b0, 4'h0);
		wr(12'h0C8, 32'h0000_0071);
		redir(8'h35, 16'h00F0, 1'b1, 4'h4);
		for (int s = 0; s < 4; s++) begin
			wr(12'h0C8, 32'h0000_0021 | (s << 8));
			redir(8'hA5, 16'hFFFF, 1'b1, flat_exp[s]);
		end
		u_nir_sw_model.send_msg(32'h1, 1'b1, 1'b1);
		for (int s = 0; s < 4; s++) begin
			wr(12'h0C8, 32'h0000_0021 | (s << 8));
			redir(8'hA5, 16'hFFFF, 1'b1, clus_exp[s]);
		end
		wr(12'h0C8, 32'h0000_0021);
		redir(8'hA5, 16'h0003, 1'b1, 4'h0);
		redir(8'hA5, 16'h0801, 1'b1, 4'hB);
		wr(12'h0C8, 32'h0000_0011);
		redir(8'hA5, 16'hFFFF, 1'b1, 4'hB);
		wr(12'h0C8, 32'h0000_0010);
		redir(8'hA5, 16'hFFFF, 1'b1, 4'h0);
	endtask : t_redirect
	////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		apply_reset();
		check("xapic reset", 32'h1, 32'(extended_apic_enable));
		t_ident_and_nodes();
		t_mode_control();
		apply_reset();
		check("force reset", 32'h0, 32'(force_second_gen_apic));
		t_redirect();
		finish_test();
	end
endmodule : tb
